// *** src/g2hbp_pkg.sv ***
// constants and types shared by the generic #2 host bus port and its host end
// assumes one 10 MHz clock and an active-low asynchronous reset at both ends
// Operation
// - 16-bit port, shared high enable, separate low enables
// - mode latched at reset release
// - input clock sources internal bus clock
// - host holds chip select low per access
// - memory/register select picks registers or buffer
// - high enable with address bit 0 steers lanes
// - host drives high enable low for 16-bit
// - host holds write enable low while writing
// - host holds read enable low while reading
// - wait held until data ready or accepted
// - wait held until arbitration completes
// - wait driven low inserts wait states when polarity strap is zero
// - bus start and direction ignored, tied high
// - byte order strap selects little endian
// - host treats device as 16-bit capable
// - host decodes a 256K byte window
// - mode pattern 0100 selects this interface
// - polarity strap: one high, zero low wait
// - two straps select bus clock divide
// - registers first 128K, buffer second 128K
package g2hbp_pkg;
	localparam int ADDR_W         = 17;
	localparam int DATA_W         = 16;
	localparam int REG_WORDS      = 64;
	localparam int MEM_WORDS      = 256;
	localparam logic [3:0] MODE_G2_LE = 4'h4;
	localparam logic [1:0] DIV_1      = 2'h0;
	localparam logic [2:0] ARB_CYCLES = 3'h2;
	localparam logic [7:0] HOST_TIMEOUT = 8'hff;
	typedef enum logic [4:0] {
		G2HBP_IDLE  = 5'b00001,
		G2HBP_ARB   = 5'b00010,
		G2HBP_XFER  = 5'b00100,
		G2HBP_DONE  = 5'b01000,
		G2HBP_HOLD  = 5'b10000
	} g2hbp_state_t;
endpackage

// *** src/g2hbp_if.sv ***
// pin bundle between the host and the display controller port
// the shared data bus is resolved here from the device enable alone
`timescale 1ns/10ps
interface g2hbp_if;
	logic [16:0] host_address_in;
	logic        host_addr_bit17;
	logic        host_display_select_n;
	logic        host_mem_read_n;
	logic        host_mem_write_n;
	logic        host_high_byte_n;
	logic        bus_start_n;
	logic        read_write_dir;
	logic [15:0] host_data_out;
	logic        host_data_oe;
	logic [15:0] dev_data_out;
	logic        dev_data_oe;
	logic [15:0] host_data_bus;
	logic        host_ready_line;
	logic        host_wide_ack_n;
	assign host_data_bus = dev_data_oe ? dev_data_out : host_data_out;
	modport device (
		input  host_address_in, host_addr_bit17, host_display_select_n, host_mem_read_n,
		input  host_mem_write_n, host_high_byte_n, bus_start_n, read_write_dir,
		input  host_data_bus,
		output dev_data_out, dev_data_oe, host_ready_line
	);
	modport host (
		output host_address_in, host_addr_bit17, host_display_select_n, host_mem_read_n,
		output host_mem_write_n, host_high_byte_n, bus_start_n, read_write_dir,
		output host_data_out, host_data_oe,
		input  host_data_bus, host_ready_line, host_wide_ack_n
	);
endinterface

// *** src/g2hbp_device.sv ***
// device end: generic #2 slave port with small register and buffer stores
// assumes host pins synchronous to REF_CLK; straps stable around reset release
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
module g2hbp_device
	import g2hbp_pkg::*;
(
	input  wire logic       REF_CLK,
	input  wire logic       RST_B,
	input  wire logic [3:0] BUS_MODE_CONFIG,
	input  wire logic       ENDIAN_CONFIG_PIN,
	input  wire logic       STALL_POLARITY_CONFIG,
	input  wire logic [1:0] CLOCK_DIVIDE_CONFIG,
	input  wire logic       REFRESH_REQ,
	g2hbp_if.device         BUS,
	output logic            MODE_ACTIVE,
	output logic            LITTLE_ENDIAN,
	output logic            BUS_CLK_EN,
	output logic            REFRESH_GRANT
);
	import g2hbp_pkg::*;

	logic               rst_seen;
	logic [3:0]         mode;
	logic               pol_high;
	logic [1:0]         div_sel;
	logic [1:0]         div_cnt;
	g2hbp_state_t       state;
	g2hbp_state_t       next_state;
	logic [2:0]         arb_cnt;
	logic [15:0]        reg_mem [REG_WORDS];
	logic [15:0]        buf_mem [MEM_WORDS];
	logic [15:0]        rdata;
	logic               stall;
	logic               active;
	logic               rd_req;
	logic               wr_req;
	logic               hi_lane;
	logic               lo_lane;
	logic [15:0]        wdata;
	logic [15:0]        rword;
	logic [7:0]         widx;

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_seen <= 1'b0;
			mode     <= 4'h0;
			pol_high <= 1'b0;
			div_sel  <= DIV_1;
			LITTLE_ENDIAN <= 1'b0;
		end else if (!rst_seen) begin
			rst_seen <= 1'b1;
			mode     <= BUS_MODE_CONFIG;
			pol_high <= STALL_POLARITY_CONFIG;
			div_sel  <= CLOCK_DIVIDE_CONFIG;
			LITTLE_ENDIAN <= ENDIAN_CONFIG_PIN;
		end
	end

	assign active = rst_seen && (mode == MODE_G2_LE) && LITTLE_ENDIAN;

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			MODE_ACTIVE <= 1'b0;
		end else begin
			MODE_ACTIVE <= active;
		end
	end

	// count input clocks per bus clock
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_cnt <= 2'h0;
		end else if (div_cnt >= div_sel) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			BUS_CLK_EN <= 1'b0;
		end else begin
			BUS_CLK_EN <= rst_seen && (div_cnt >= div_sel);
		end
	end

	assign rd_req = active && !BUS.host_display_select_n && !BUS.host_mem_read_n;
	assign wr_req = active && !BUS.host_display_select_n && !BUS.host_mem_write_n;

	assign hi_lane = !BUS.host_high_byte_n || BUS.host_address_in[0];
	assign lo_lane = !BUS.host_address_in[0];
	assign widx    = BUS.host_address_in[8:1];

	always_comb begin
		wdata = BUS.host_data_bus;
		if (BUS.host_address_in[0] && BUS.host_high_byte_n) begin
			wdata = {BUS.host_data_bus[7:0], BUS.host_data_bus[7:0]};
		end
	end

	assign rword = BUS.host_addr_bit17 ? buf_mem[widx] : reg_mem[widx[5:0]];

	always_comb begin
		next_state = state;
		unique case (state)
			G2HBP_IDLE: begin
				if (rd_req || wr_req) begin
					next_state = G2HBP_ARB;
				end
			end
			G2HBP_ARB: begin
				if (arb_cnt == 3'h0 && BUS_CLK_EN && !REFRESH_REQ) begin
					next_state = G2HBP_XFER;
				end
			end
			G2HBP_XFER: next_state = G2HBP_DONE;
			G2HBP_DONE: next_state = G2HBP_HOLD;
			G2HBP_HOLD: begin
				if (!rd_req && !wr_req) begin
					next_state = G2HBP_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= G2HBP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			arb_cnt <= ARB_CYCLES;
		end else if (state != G2HBP_ARB) begin
			arb_cnt <= ARB_CYCLES;
		end else if (arb_cnt != 3'h0) begin
			arb_cnt <= arb_cnt - 3'h1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			REFRESH_GRANT <= 1'b0;
		end else begin
			REFRESH_GRANT <= REFRESH_REQ && (state != G2HBP_XFER) && (state != G2HBP_ARB);
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (state == G2HBP_XFER && wr_req) begin
			if (BUS.host_addr_bit17) begin
				if (hi_lane) buf_mem[widx][15:8] <= wdata[15:8];
				if (lo_lane) buf_mem[widx][7:0]  <= wdata[7:0];
			end else begin
				if (hi_lane) reg_mem[widx[5:0]][15:8] <= wdata[15:8];
				if (lo_lane) reg_mem[widx[5:0]][7:0]  <= wdata[7:0];
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata <= 16'h0000;
		end else if (state == G2HBP_XFER && rd_req) begin
			rdata <= (BUS.host_address_in[0] && BUS.host_high_byte_n) ?
				{8'h00, rword[15:8]} : rword;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			BUS.dev_data_oe <= 1'b0;
		end else begin
			BUS.dev_data_oe <= rd_req && (state != G2HBP_IDLE);
		end
	end
	assign BUS.dev_data_out = rdata;

	assign stall = (rd_req || wr_req) && (state != G2HBP_DONE) && (state != G2HBP_HOLD);

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			BUS.host_ready_line <= 1'b1;
		end else begin
			BUS.host_ready_line <= pol_high ? stall : !stall;
		end
	end
endmodule

// *** src/g2hbp_host.sv ***
// host end: issues one read or write per command and waits on ready
// assumes the device wait output is active low
`timescale 1ns/10ps
module g2hbp_host
	import g2hbp_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RST_B,
	input  wire logic [17:0] CMD_ADDR,
	input  wire logic [15:0] CMD_WDATA,
	input  wire logic        CMD_WRITE,
	input  wire logic        CMD_READ,
	input  wire logic        CMD_BYTE,
	g2hbp_if.host            BUS,
	output logic             BUSY,
	output logic [15:0]      RDATA,
	output logic             DONE,
	output logic             TIMEOUT
);
	import g2hbp_pkg::*;

	logic       rd;
	logic       run;
	logic [1:0] settle;
	logic [7:0] tmo;

	assign BUS.bus_start_n    = 1'b1;
	assign BUS.read_write_dir = 1'b1;

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			run <= 1'b0;
			rd  <= 1'b0;
			settle <= 2'h0;
			tmo <= 8'h00;
			BUSY <= 1'b0;
			DONE <= 1'b0;
			TIMEOUT <= 1'b0;
			RDATA <= 16'h0000;
			BUS.host_address_in       <= 17'h00000;
			BUS.host_addr_bit17       <= 1'b0;
			BUS.host_display_select_n <= 1'b1;
			BUS.host_mem_read_n       <= 1'b1;
			BUS.host_mem_write_n      <= 1'b1;
			BUS.host_high_byte_n      <= 1'b1;
			BUS.host_data_out         <= 16'h0000;
			BUS.host_data_oe          <= 1'b0;
		end else begin
			DONE <= 1'b0;
			TIMEOUT <= 1'b0;
			if (!run && (CMD_READ || CMD_WRITE)) begin
				run <= 1'b1;
				BUSY <= 1'b1;
				rd  <= CMD_READ;
				settle <= 2'h2;
				tmo <= 8'h00;
				BUS.host_address_in <= CMD_ADDR[16:0];
				BUS.host_addr_bit17 <= CMD_ADDR[17];
				BUS.host_display_select_n <= 1'b0;
				BUS.host_mem_read_n  <= !CMD_READ;
				BUS.host_mem_write_n <= CMD_READ;
				BUS.host_high_byte_n <= CMD_BYTE;
				BUS.host_data_out <= CMD_WDATA;
				BUS.host_data_oe  <= !CMD_READ;
			end else if (run) begin
				tmo <= tmo + 8'h01;
				if (settle != 2'h0) begin
					settle <= settle - 2'h1;
				end else if (BUS.host_ready_line || tmo == HOST_TIMEOUT) begin
					run  <= 1'b0;
					BUSY <= 1'b0;
					DONE <= BUS.host_ready_line;
					TIMEOUT <= !BUS.host_ready_line;
					if (rd) RDATA <= BUS.host_data_bus;
					BUS.host_display_select_n <= 1'b1;
					BUS.host_mem_read_n  <= 1'b1;
					BUS.host_mem_write_n <= 1'b1;
					BUS.host_high_byte_n <= 1'b1;
					BUS.host_data_oe     <= 1'b0;
				end
			end
		end
	end
endmodule

// *** verif/g2hbp_sva.sv ***
// checker for the pin bundle between the host end and the device end
// assumes active-low wait (polarity strap 0) and one clock
`timescale 1ns/10ps
module g2hbp_sva (
	input  wire logic REF_CLK,
	input  wire logic RST_B,
	input  wire logic host_display_select_n,
	input  wire logic host_mem_read_n,
	input  wire logic host_mem_write_n,
	input  wire logic bus_start_n,
	input  wire logic read_write_dir,
	input  wire logic host_ready_line,
	input  wire logic host_data_oe,
	input  wire logic dev_data_oe
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	strobe_excl_a: assert property (host_mem_read_n || host_mem_write_n)
		else $error("both strobes low");
	read_hold_a: assert property (!host_mem_read_n && !host_ready_line
		|=> !host_mem_read_n && !host_display_select_n) else $error("read dropped in wait");
	write_hold_a: assert property (!host_mem_write_n && !host_ready_line
		|=> !host_mem_write_n && !host_display_select_n) else $error("write dropped in wait");
	tied_high_a: assert property (bus_start_n && read_write_dir)
		else $error("unused pins not high");
	wait_start_a: assert property ($fell(host_mem_read_n) || $fell(host_mem_write_n)
		|-> ##[0:3] !host_ready_line) else $error("no wait inserted");
	wait_min_a: assert property ($fell(host_ready_line) |-> !host_ready_line[*3])
		else $error("wait too short");
	wait_bound_a: assert property ($fell(host_ready_line) |-> ##[1:60] host_ready_line)
		else $error("wait never released");
	read_data_a: assert property ($rose(host_ready_line) && !host_mem_read_n
		|-> dev_data_oe) else $error("read data not driven");
	bus_owner_a: assert property (dev_data_oe |-> !host_data_oe)
		else $error("data bus driven twice");
	cover property ($rose(host_ready_line) && !host_mem_read_n);
	cover property ($rose(host_ready_line) && !host_mem_write_n);
	cover property (!host_ready_line [*5]);
endmodule

// *** verif/testbench.sv ***
// self-checking bench: host end drives device end over the pin bundle
// assumes the package constants and a 10 MHz clock
`timescale 1ns/10ps
module testbench;
	import g2hbp_pkg::*;
	logic        REF_CLK = 0;
	logic        RST_B = 0;
	logic [3:0]  mode = MODE_G2_LE;
	logic [1:0]  div = DIV_1;
	logic        endian = 1;
	logic        pol = 0;
	logic        refresh = 0;
	logic [17:0] cmd_addr = 0;
	logic [15:0] cmd_wdata = 0;
	logic        cmd_write = 0;
	logic        cmd_read = 0;
	logic        cmd_byte = 0;
	logic        mode_active, little_endian, bus_clk_en, refresh_grant;
	logic        busy, done, timeout, b;
	logic [15:0] rdata;
	logic [15:0] mem [int];
	int          n_fail = 0;
	int          n_compared = 0;
	int          cycles = 0;
	g2hbp_if bus ();
	assign bus.host_wide_ack_n = bus.host_display_select_n;
	g2hbp_device u_g2hbp_device (.REF_CLK(REF_CLK), .RST_B(RST_B), .BUS_MODE_CONFIG(mode),
		.ENDIAN_CONFIG_PIN(endian), .STALL_POLARITY_CONFIG(pol), .CLOCK_DIVIDE_CONFIG(div),
		.REFRESH_REQ(refresh), .BUS(bus), .MODE_ACTIVE(mode_active),
		.LITTLE_ENDIAN(little_endian), .BUS_CLK_EN(bus_clk_en), .REFRESH_GRANT(refresh_grant));
	g2hbp_host u_g2hbp_host (.REF_CLK(REF_CLK), .RST_B(RST_B), .CMD_ADDR(cmd_addr),
		.CMD_WDATA(cmd_wdata), .CMD_WRITE(cmd_write), .CMD_READ(cmd_read), .CMD_BYTE(cmd_byte),
		.BUS(bus), .BUSY(busy), .RDATA(rdata), .DONE(done), .TIMEOUT(timeout));
	g2hbp_sva u_g2hbp_sva (.REF_CLK(REF_CLK), .RST_B(RST_B),
		.host_display_select_n(bus.host_display_select_n),
		.host_mem_read_n(bus.host_mem_read_n), .host_mem_write_n(bus.host_mem_write_n),
		.bus_start_n(bus.bus_start_n), .read_write_dir(bus.read_write_dir),
		.host_ready_line(bus.host_ready_line), .host_data_oe(bus.host_data_oe),
		.dev_data_oe(bus.dev_data_oe));
	always #50 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) begin
		refresh <= ($urandom % 4) == 0;
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (n_fail == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic restart(input logic [3:0] m, input logic [1:0] d, input logic e, input logic p);
		@(posedge REF_CLK);
		RST_B <= 0;
		mode <= m;
		div <= d;
		endian <= e;
		pol <= p;
		repeat (2) @(posedge REF_CLK);
		RST_B <= 1;
		repeat (3) @(posedge REF_CLK);
		#1;
	endtask
	task automatic count_clk_en(input int d);
		int n;
		logic r;
		n = 0;
		repeat (12) begin
			r = refresh;
			@(posedge REF_CLK);
			#1;
			n += (bus_clk_en === 1'b1);
			check("refresh grant", 16'(r), 16'(refresh_grant));
		end
		check("clock enables", 16'(12 / (d + 1)), 16'(n));
	endtask
	task automatic op(input logic wr, input logic [17:0] a, input logic byt, input logic [15:0] d);
		int k;
		int key;
		logic [15:0] e;
		k = 0;
		key = {a[17], a[8:1]};
		@(posedge REF_CLK);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_byte <= byt;
		cmd_write <= wr;
		cmd_read <= !wr;
		@(posedge REF_CLK);
		cmd_write <= 0;
		cmd_read <= 0;
		do begin
			@(posedge REF_CLK);
			#1;
			k++;
			if (k == 1)
				check("busy", 1, busy);
		end while (done !== 1'b1 && k < 300);
		check("done", 1, done);
		check("busy", 0, busy);
		check("timeout", 0, timeout);
		e = mem.exists(key) ? mem[key] : 16'h0;
		if (wr && !byt)
			mem[key] = d;
		else if (wr && a[0])
			mem[key] = {d[7:0], e[7:0]};
		else if (wr)
			mem[key] = {e[15:8], d[7:0]};
		else if (!byt)
			check("word read", e, rdata);
		else
			check("byte read", {8'h0, a[0] ? e[15:8] : e[7:0]}, {8'h0, rdata[7:0]});
	endtask
	initial begin
		void'($urandom(32'h0e451cd8));
		for (int d = 0; d < 4; d++) begin
			restart(MODE_G2_LE, 2'(d), 1'b1, 1'b0);
			check("mode active", 1, mode_active);
			check("little endian", 1, little_endian);
			count_clk_en(d);
		end
		restart(4'h5, DIV_1, 1'b1, 1'b0);
		check("bad mode", 0, mode_active);
		restart(MODE_G2_LE, DIV_1, 1'b0, 1'b0);
		check("bad endian", 0, mode_active);
		restart(MODE_G2_LE, DIV_1, 1'b1, 1'b1);
		check("wait idle active high", 0, bus.host_ready_line);
		restart(MODE_G2_LE, DIV_1, 1'b1, 1'b0);
		check("wait idle active low", 1, bus.host_ready_line);
		for (int i = 0; i < 16; i++)
			op(1, {i[3], 13'h0, i[2:0], 1'b0}, 0, 16'($urandom));
		for (int i = 0; i < 60; i++) begin
			b = 1'($urandom);
			op(1'($urandom), {1'($urandom), 13'h0, 3'($urandom), b & 1'($urandom)}, b,
				16'($urandom));
		end
		complete_run();
	end
endmodule
